// ===== hw/sci_top.sv
// system control, clock dividers and interrupt aggregation
// Summary of operation
// - engine speed bit 4; zero gives 2 MHz engine, one reserved.
// - bit 3 enables touch sensor sleep; host should keep it zero.
// - writing one to bit 1 triggers a soft reset.
// - writing one to bit 0 forces hibernate.
// - hibernate bit always reads zero; the read access wakes the device.
// - control bits 7:5 and 2 read zero; host must not write ones.
// - sensor divider codes 010..111 give 32..1024; 000, 001 reserved.
// - sensor clock is 2 MHz over divisor times pseudo-random 1..8.
// - pwm divider codes 00..11 give 16, 32, 64, 128 kHz.
// - clock divider bits 2,1,0 stop pwm, gpio, sensor clocks.
// - irq control bit 2 sets output polarity, one is active high.
// - irq control bit 1 selects level (0) or edge (1) signalling.
// - irq control bit 0 globally enables the interrupt output.
// - status bits latch per source, write one clears; bit 0 reserved.
// - bit 7 sets on gpio activity, bit 6 on pwm sequence done.
// - bit 5 sets on wake-up from sleep or hibernate.
// - bit 4 sets on ambient fault; host should recalibrate.
// - bit 3 sets when host-started calibration completes.
// - bit 2 sets on touch, bit 1 on proximity detection.
// - enable register gates each source at the same bit position.
// - filtered key data active only while touch enable is set.
// - 16 gpio sub-status bits set on transition, write one clears, feed bit 7.
// - 8 pwm sub-status bits set on done, write one clears, feed bit 6.
module sci_top
    import sci_pkg::*;
(
    input  wire logic         clk_in,
    input  wire logic         sys_rst_in,
    input  wire sci_reg_req_t reg_req_in,
    input  wire sci_events_t  events_in,
    output logic [7:0]        rd_data_out,
    output logic              irq_out,
    output logic              soft_reset_out,
    output logic              hibernate_out,
    output logic              sleep_enable_out,
    output logic              engine_tick_out,
    output logic              sensor_tick_out,
    output logic              pwm_tick_out,
    output logic              pwm_clk_stop_out,
    output logic              gpio_clk_stop_out,
    output logic              sense_clk_stop_out,
    output logic              key_filter_enable_out
);

    // soft reset clears the register file one cycle after the write
    logic        soft_rst;
    wire         blk_rst = sys_rst_in | soft_rst;

    logic [7:0]  gen_ctrl;
    logic [7:0]  clk_div;
    logic [2:0]  irq_ctrl;
    logic [7:0]  irq_sta;
    logic [7:0]  irq_en;
    logic [15:0] pin_sta;
    logic [15:0] pin_en;
    logic [7:0]  pulse_sta;
    logic [7:0]  pulse_en;
    logic        hibernate;
    logic [7:0]  masked_prev;

    // ---------------- address decode ----------------
    wire [7:0] a  = reg_req_in.addr;
    wire [7:0] wd = reg_req_in.wdata;
    wire       wr = reg_req_in.wr;
    wire       rd = reg_req_in.rd;

    wire wr_gen       = wr && (a == OFS_GEN_CTRL);
    wire wr_cdv       = wr && (a == OFS_CLK_DIV);
    wire wr_icr       = wr && (a == OFS_IRQ_CTRL);
    wire wr_ista      = wr && (a == OFS_IRQ_STA);
    wire wr_ien       = wr && (a == OFS_IRQ_EN);
    wire wr_psta_lo   = wr && (a == OFS_PIN_STA_LSB);
    wire wr_psta_hi   = wr && (a == OFS_PIN_STA_MSB);
    wire wr_pen_lo    = wr && (a == OFS_PIN_EN_LSB);
    wire wr_pen_hi    = wr && (a == OFS_PIN_EN_MSB);
    wire wr_usta      = wr && (a == OFS_PULSE_STA);
    wire wr_uen       = wr && (a == OFS_PULSE_EN);

    // ---------------- status logic ----------------
    wire [15:0] pin_clr   = {wr_psta_hi ? wd : 8'h00, wr_psta_lo ? wd : 8'h00};
    wire [15:0] next_pin_sta = (pin_sta & ~pin_clr) | events_in.pin_change;
    wire [7:0]  pulse_clr = wr_usta ? wd : 8'h00;
    wire [7:0]  next_pulse_sta = (pulse_sta & ~pulse_clr) | events_in.pulse_done;

    // leaving hibernate on any serial access except a write setting the hibernate bit raises the resume source
    wire hib_set   = wr_gen && wd[GEN_HIBERNATE];
    wire hib_wake  = hibernate && (rd || wr) && !hib_set;

    // sub-status feeds the top bit as a level, so clearing only the top bit re-sets it
    wire pin_any   = |(pin_sta & pin_en);
    wire pulse_any = |(pulse_sta & pulse_en);

    wire [7:0] irq_set;
    assign irq_set[IRQ_PIN]     = pin_any;
    assign irq_set[IRQ_PULSE]   = pulse_any;
    assign irq_set[IRQ_RESUME]  = hib_wake | events_in.sleep_resume;
    assign irq_set[IRQ_AMBIENT] = events_in.ambient_fault;
    assign irq_set[IRQ_CAL]     = events_in.cal_done;
    assign irq_set[IRQ_TOUCH]   = events_in.touch;
    assign irq_set[IRQ_NEAR]    = events_in.nearness;
    assign irq_set[0]           = 1'b0;

    wire [7:0] irq_clr      = wr_ista ? wd : 8'h00;
    wire [7:0] next_irq_sta = ((irq_sta & ~irq_clr) | irq_set) & IRQ_VALID_MASK;

    // ---------------- interrupt output ----------------
    wire [7:0] masked    = irq_sta & irq_en;
    wire       pending   = irq_ctrl[ICR_GEN] && (|masked);
    wire       new_event = irq_ctrl[ICR_GEN] && (|(masked & ~masked_prev));
    wire       irq_active = irq_ctrl[ICR_EDGE] ? new_event : pending;
    wire       next_irq  = irq_ctrl[ICR_POL] ? irq_active : !irq_active;

    // ---------------- read mux ----------------
    logic [7:0] next_rd_data;
    always_comb
    begin
        unique case (a)
            OFS_CHIP_IDENTITY_LSB: next_rd_data = CHIP_IDENTITY_VALUE[7:0];
            OFS_CHIP_IDENTITY_MSB: next_rd_data = CHIP_IDENTITY_VALUE[15:8];
            OFS_SI_VERSION:  next_rd_data = VERSION_VALUE;
            OFS_GEN_CTRL:    next_rd_data = gen_ctrl & GEN_RW_MASK;
            OFS_CLK_DIV:     next_rd_data = clk_div;
            OFS_IRQ_CTRL:    next_rd_data = {5'h00, irq_ctrl};
            OFS_IRQ_STA:     next_rd_data = irq_sta;
            OFS_IRQ_EN:      next_rd_data = irq_en;
            OFS_PIN_STA_LSB: next_rd_data = pin_sta[7:0];
            OFS_PIN_STA_MSB: next_rd_data = pin_sta[15:8];
            OFS_PIN_EN_LSB:  next_rd_data = pin_en[7:0];
            OFS_PIN_EN_MSB:  next_rd_data = pin_en[15:8];
            OFS_PULSE_STA:   next_rd_data = pulse_sta;
            OFS_PULSE_EN:    next_rd_data = pulse_en;
            default:         next_rd_data = 8'h00;
        endcase
    end

    // ---------------- register file ----------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            soft_rst <= 1'b0;
        end
        else
        begin
            soft_rst <= wr_gen && wd[GEN_SOFT_RST];
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (blk_rst)
        begin
            gen_ctrl    <= RST_GEN_CTRL;
            clk_div     <= RST_CLK_DIV;
            irq_ctrl    <= RST_IRQ_CTRL;
            irq_en      <= RST_IRQ_EN;
            pin_en      <= RST_PIN_WORD;
            pulse_en    <= RST_PULSE;
        end
        else
        begin
            if (wr_gen)
                gen_ctrl <= wd & GEN_RW_MASK;
            if (wr_cdv)
                clk_div <= wd;
            if (wr_icr)
                irq_ctrl <= wd[2:0];
            if (wr_ien)
                irq_en <= wd & IRQ_VALID_MASK;
            if (wr_pen_lo)
                pin_en[7:0] <= wd;
            if (wr_pen_hi)
                pin_en[15:8] <= wd;
            if (wr_uen)
                pulse_en <= wd;
        end
    end

    always_ff @(posedge clk_in)
    begin
        if (blk_rst)
        begin
            irq_sta     <= RST_IRQ_STA;
            pin_sta     <= RST_PIN_WORD;
            pulse_sta   <= RST_PULSE;
            hibernate   <= 1'b0;
            masked_prev <= RST_IRQ_STA;
        end
        else
        begin
            irq_sta     <= next_irq_sta;
            pin_sta     <= next_pin_sta;
            pulse_sta   <= next_pulse_sta;
            hibernate   <= hib_set | (hibernate & ~hib_wake);
            masked_prev <= masked;
        end
    end

    // ---------------- engine clock: 2 MHz from the system clock ----------------
    logic [5:0] eng_cnt;
    wire        eng_tick = (eng_cnt == ENGINE_LAST);

    always_ff @(posedge clk_in)
    begin
        if (blk_rst)
            eng_cnt <= 6'h00;
        else
            eng_cnt <= eng_tick ? 6'h00 : eng_cnt + 6'h01;
    end

    // ---------------- sensor clock ----------------
    // lfsr spreads sampling against interference; factor 1..8
    logic [7:0]  lfsr;
    logic [13:0] sns_cnt;
    wire  [2:0]  sns_code   = clk_div[CDV_SENSE_HI:CDV_SENSE_LO];
    wire         sns_legal  = (sns_code >= SENSE_CODE_MIN);
    // four-bit shift amount: code 111 needs 10, which three bits would wrap
    wire  [10:0] sns_div    = 11'h001 << ({1'b0, sns_code} + 4'h3);
    wire  [3:0]  sns_factor = {1'b0, lfsr[2:0]} + 4'h1;
    wire  [14:0] sns_target = 15'(sns_div * sns_factor);
    wire         sns_run    = sns_legal && !clk_div[CDV_SENSE_STOP] && !hibernate;
    wire         sns_hit    = sns_run && eng_tick && ({1'b0, sns_cnt} >= sns_target - 15'h0001);

    always_ff @(posedge clk_in)
    begin
        if (blk_rst)
        begin
            lfsr    <= RST_LFSR;
            sns_cnt <= 14'h0000;
        end
        else
        begin
            if (sns_hit)
            begin
                lfsr    <= {lfsr[6:0], lfsr[7] ^ lfsr[5] ^ lfsr[4] ^ lfsr[3]};
                sns_cnt <= 14'h0000;
            end
            else if (!sns_run)
                sns_cnt <= 14'h0000;
            else if (eng_tick)
                sns_cnt <= sns_cnt + 14'h0001;
        end
    end

    // ---------------- pwm clock ----------------
    // fractional accumulator: exact average rate although 100 MHz is no integer multiple of 64 or 128 kHz
    logic [26:0] pwm_acc;
    wire  [26:0] pwm_inc  = PWM_ACC_BASE << clk_div[CDV_PWM_HI:CDV_PWM_LO];
    wire  [27:0] pwm_sum  = {1'b0, pwm_acc} + {1'b0, pwm_inc};
    wire         pwm_wrap = (pwm_sum >= {1'b0, PWM_ACC_MOD});
    wire         pwm_run  = !clk_div[CDV_PWM_STOP] && !hibernate;

    always_ff @(posedge clk_in)
    begin
        if (blk_rst || !pwm_run)
            pwm_acc <= 27'h0000000;
        else if (pwm_wrap)
            pwm_acc <= 27'(pwm_sum - {1'b0, PWM_ACC_MOD});
        else
            pwm_acc <= pwm_sum[26:0];
    end

    // ---------------- outputs ----------------
    always_ff @(posedge clk_in)
    begin
        if (sys_rst_in)
        begin
            rd_data_out           <= 8'h00;
            irq_out               <= 1'b1;
            soft_reset_out        <= 1'b0;
            hibernate_out         <= 1'b0;
            sleep_enable_out      <= 1'b0;
            engine_tick_out       <= 1'b0;
            sensor_tick_out       <= 1'b0;
            pwm_tick_out          <= 1'b0;
            pwm_clk_stop_out      <= RST_CLK_DIV[CDV_PWM_STOP];
            gpio_clk_stop_out     <= RST_CLK_DIV[CDV_GPIO_STOP];
            sense_clk_stop_out    <= RST_CLK_DIV[CDV_SENSE_STOP];
            key_filter_enable_out <= 1'b0;
        end
        else
        begin
            rd_data_out           <= rd ? next_rd_data : rd_data_out;
            irq_out               <= next_irq;
            soft_reset_out        <= soft_rst;
            hibernate_out         <= hibernate;
            sleep_enable_out      <= gen_ctrl[GEN_SLEEP_EN];
            engine_tick_out       <= eng_tick;
            sensor_tick_out       <= sns_hit;
            pwm_tick_out          <= pwm_run && pwm_wrap;
            pwm_clk_stop_out      <= clk_div[CDV_PWM_STOP];
            gpio_clk_stop_out     <= clk_div[CDV_GPIO_STOP];
            sense_clk_stop_out    <= clk_div[CDV_SENSE_STOP];
            key_filter_enable_out <= irq_en[IRQ_TOUCH];
        end
    end

endmodule

// ===== shared/sci_pkg.sv
// package with register map, field layout and carriers of the system control and interrupt block
package sci_pkg;

    // register byte offsets; 16-bit registers use offset for lsb, offset+1 for msb
    localparam logic [7:0] OFS_CHIP_IDENTITY_LSB  = 8'h00;
    localparam logic [7:0] OFS_CHIP_IDENTITY_MSB  = 8'h01;
    localparam logic [7:0] OFS_SI_VERSION   = 8'h02;
    localparam logic [7:0] OFS_GEN_CTRL     = 8'h03;
    localparam logic [7:0] OFS_CLK_DIV      = 8'h04;
    localparam logic [7:0] OFS_IRQ_CTRL     = 8'h06;
    localparam logic [7:0] OFS_IRQ_STA      = 8'h08;
    localparam logic [7:0] OFS_IRQ_EN       = 8'h09;
    localparam logic [7:0] OFS_PIN_STA_LSB  = 8'h0a;
    localparam logic [7:0] OFS_PIN_STA_MSB  = 8'h0b;
    localparam logic [7:0] OFS_PIN_EN_LSB   = 8'h0c;
    localparam logic [7:0] OFS_PIN_EN_MSB   = 8'h0d;
    localparam logic [7:0] OFS_PULSE_STA    = 8'h0e;
    localparam logic [7:0] OFS_PULSE_EN     = 8'h0f;

    // reset values
    localparam logic [7:0]  RST_GEN_CTRL  = 8'h00;
    localparam logic [7:0]  RST_CLK_DIV   = 8'hfe;
    localparam logic [2:0]  RST_IRQ_CTRL  = 3'h0;
    localparam logic [7:0]  RST_IRQ_STA   = 8'h00;
    localparam logic [7:0]  RST_IRQ_EN    = 8'h00;
    localparam logic [15:0] RST_PIN_WORD  = 16'h0000;
    localparam logic [7:0]  RST_PULSE     = 8'h00;
    localparam logic [7:0]  RST_LFSR      = 8'h01;

    // identity values: arbitrary, not tied to any part
    localparam logic [15:0] CHIP_IDENTITY_VALUE = 16'h5a5a;
    localparam logic [7:0]  VERSION_VALUE = 8'h01;

    // general control fields
    localparam int GEN_ENGINE_SPEED = 4;
    localparam int GEN_SLEEP_EN     = 3;
    localparam int GEN_SOFT_RST     = 1;
    localparam int GEN_HIBERNATE    = 0;
    localparam logic [7:0] GEN_RW_MASK = 8'h18;

    // clock divider fields
    localparam int CDV_SENSE_HI = 7;
    localparam int CDV_SENSE_LO = 5;
    localparam int CDV_PWM_HI   = 4;
    localparam int CDV_PWM_LO   = 3;
    localparam int CDV_PWM_STOP = 2;
    localparam int CDV_GPIO_STOP = 1;
    localparam int CDV_SENSE_STOP = 0;
    localparam logic [2:0] SENSE_CODE_MIN = 3'h2;

    // irq control fields
    localparam int ICR_POL  = 2;
    localparam int ICR_EDGE = 1;
    localparam int ICR_GEN  = 0;

    // irq status / enable bit positions
    localparam int IRQ_PIN    = 7;
    localparam int IRQ_PULSE  = 6;
    localparam int IRQ_RESUME = 5;
    localparam int IRQ_AMBIENT = 4;
    localparam int IRQ_CAL    = 3;
    localparam int IRQ_TOUCH  = 2;
    localparam int IRQ_NEAR   = 1;
    localparam logic [7:0] IRQ_VALID_MASK = 8'hfe;

    // timing
    localparam longint CLK_HZ        = 100_000_000;
    localparam longint ENGINE_HZ     = 2_000_000;
    localparam int     ENGINE_DIV    = int'(CLK_HZ / ENGINE_HZ);
    localparam logic [5:0] ENGINE_LAST = 6'(ENGINE_DIV - 1);
    localparam longint PWM_BASE_HZ   = 16_000;
    localparam logic [26:0] PWM_ACC_MOD  = 27'(CLK_HZ);
    localparam logic [26:0] PWM_ACC_BASE = 27'(PWM_BASE_HZ);

    // byte-wide register port from the serial front end
    typedef struct packed {
        logic [7:0] addr;
        logic [7:0] wdata;
        logic       wr;
        logic       rd;
    } sci_reg_req_t;

    // event pulses from the neighbouring modules
    typedef struct packed {
        logic [15:0] pin_change;
        logic [7:0]  pulse_done;
        logic        sleep_resume;
        logic        ambient_fault;
        logic        cal_done;
        logic        touch;
        logic        nearness;
    } sci_events_t;

endpackage

// ===== verif/sci_top_asserts.sv
// port-level checks of the system control and interrupt block
module sci_top_asserts
    import sci_pkg::*;
(
    input wire logic         clk_in,
    input wire logic         sys_rst_in,
    input wire sci_reg_req_t reg_req_in,
    input wire logic [7:0]   rd_data_out,
    input wire logic         irq_out,
    input wire logic         soft_reset_out,
    input wire logic         hibernate_out,
    input wire logic         sleep_enable_out,
    input wire logic         engine_tick_out,
    input wire logic         pwm_clk_stop_out,
    input wire logic         gpio_clk_stop_out,
    input wire logic         sense_clk_stop_out,
    input wire logic         key_filter_enable_out
);
    timeunit 1ns;
    timeprecision 1ps;
    wire        wr  = reg_req_in.wr;
    wire        rd  = reg_req_in.rd;
    wire [7:0]  adr = reg_req_in.addr;
    wire [7:0]  wd  = reg_req_in.wdata;
    logic       srst_pend;
    logic [2:0] sh_ctrl;
    logic [2:0] sh_ctrl_d;
    // shadow of irq control; a soft reset clears it at the edge after the write, like the block
    always_ff @(posedge clk_in)
    begin
        srst_pend <= !sys_rst_in && wr && adr == OFS_GEN_CTRL && wd[GEN_SOFT_RST];
        sh_ctrl   <= (sys_rst_in || srst_pend) ? RST_IRQ_CTRL : (wr && adr == OFS_IRQ_CTRL) ? wd[2:0] : sh_ctrl;
        sh_ctrl_d <= sh_ctrl;
    end
    default clocking @(posedge clk_in); endclocking
    default disable iff (sys_rst_in);
    a_irq_global_off: assert property (!sh_ctrl_d[ICR_GEN] |-> irq_out == !sh_ctrl_d[ICR_POL])
        else $error("irq active while disabled");
    a_sleep_follows: assert property (wr && adr == OFS_GEN_CTRL ##1 !wr |->
        ##1 sleep_enable_out == $past(wd[GEN_SLEEP_EN], 2)) else $error("sleep enable wrong");
    a_soft_reset_pulse: assert property (wr && adr == OFS_GEN_CTRL && wd[GEN_SOFT_RST] |->
        ##[2:3] soft_reset_out ##1 !soft_reset_out) else $error("soft reset pulse missing");
    a_clock_stops: assert property (wr && adr == OFS_CLK_DIV ##1 !wr |->
        ##1 {pwm_clk_stop_out, gpio_clk_stop_out, sense_clk_stop_out} == $past(wd[2:0], 2))
        else $error("clock stop wrong");
    a_key_filter: assert property (wr && adr == OFS_IRQ_EN ##1 !wr |->
        ##1 key_filter_enable_out == $past(wd[IRQ_TOUCH], 2)) else $error("key filter wrong");
    a_ctrl_reserved: assert property (rd && adr == OFS_GEN_CTRL |=> (rd_data_out & 8'he7) == 8'h00)
        else $error("reserved control bits read high");
    a_hibernate_wake: assert property (rd && hibernate_out |-> ##[1:3] !hibernate_out)
        else $error("hibernate not left on read");
    a_engine_rate: assert property (disable iff (sys_rst_in || soft_reset_out)
        engine_tick_out |=> !engine_tick_out [*8] ##42 engine_tick_out) else $error("engine tick period wrong");
endmodule

bind sci_top sci_top_asserts u_sci_top_asserts (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(reg_req_in),
    .rd_data_out(rd_data_out), .irq_out(irq_out), .soft_reset_out(soft_reset_out), .hibernate_out(hibernate_out),
    .sleep_enable_out(sleep_enable_out), .engine_tick_out(engine_tick_out), .pwm_clk_stop_out(pwm_clk_stop_out),
    .gpio_clk_stop_out(gpio_clk_stop_out), .sense_clk_stop_out(sense_clk_stop_out),
    .key_filter_enable_out(key_filter_enable_out));

// ===== verif/sci_host_model.sv
// host model issuing byte reads and writes on the register port
module sci_host_model
    import sci_pkg::*;
(
    input  wire logic       clk_in,
    input  wire logic [7:0] rd_data_in,
    output sci_reg_req_t    req_out
);
    timeunit 1ns;
    timeprecision 1ps;
    int gap = 0;
    initial req_out = '0;
    // only this block's registers are reached, never a module with a stopped clock
    task automatic idle();
        repeat (gap) @(posedge clk_in);
    endtask
    // reserved control bits are masked off so the host never sets them
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        idle();
        @(posedge clk_in);
        req_out <= '{addr: addr, wdata: (addr == OFS_GEN_CTRL) ? (data & 8'h1b) : data, wr: 1'b1, rd: 1'b0};
        @(posedge clk_in);
        req_out <= '{addr: ~addr, wdata: ~data, wr: 1'b0, rd: 1'b0};
    endtask
    task automatic rd(input logic [7:0] addr, output logic [7:0] data);
        idle();
        @(posedge clk_in);
        req_out <= '{addr: addr, wdata: 8'h00, wr: 1'b0, rd: 1'b1};
        @(posedge clk_in);
        req_out <= '{addr: ~addr, wdata: 8'hff, wr: 1'b0, rd: 1'b0};
        @(posedge clk_in);
        data = rd_data_in;
    endtask
endmodule

// ===== verif/sci_top_tb_top.sv
// self-checking bench of the system control and interrupt block
module sci_top_tb_top
    import sci_pkg::*;
;
    timeunit 1ns;
    timeprecision 1ps;
    logic         clk_in     = 1'b0;
    logic         sys_rst_in = 1'b1;
    sci_reg_req_t reg_req;
    sci_events_t  ev         = '0;
    logic [7:0]   rd_data;
    logic         irq, srst, hib, slp, eng, sen, ptk, pst, gst, sst, kfe;
    int           errors     = 0;
    int           num_checks = 0;

    sci_top u_sci_top (.clk_in(clk_in), .sys_rst_in(sys_rst_in), .reg_req_in(reg_req), .events_in(ev),
        .rd_data_out(rd_data), .irq_out(irq), .soft_reset_out(srst), .hibernate_out(hib), .sleep_enable_out(slp),
        .engine_tick_out(eng), .sensor_tick_out(sen), .pwm_tick_out(ptk), .pwm_clk_stop_out(pst),
        .gpio_clk_stop_out(gst), .sense_clk_stop_out(sst), .key_filter_enable_out(kfe));
    sci_host_model u_sci_host_model (.clk_in(clk_in), .rd_data_in(rd_data), .req_out(reg_req));

    task automatic conclude();
        if (errors == 0 && num_checks > 0)
            $display("SIMULATION PASSED");
        else
            $display("SIMULATION FAILED");
        $finish;
    endtask
    task automatic chk(input string name, input logic [15:0] exp, input logic [15:0] seen);
        num_checks++;
        if (seen !== exp)
        begin
            errors++;
            $display("MISMATCH %s expected %h seen %h", name, exp, seen);
        end
    endtask
    task automatic rchk(input logic [7:0] addr, input logic [7:0] exp);
        logic [7:0] v;
        u_sci_host_model.rd(addr, v);
        chk($sformatf("register %h", addr), {8'h00, exp}, {8'h00, v});
    endtask
    task automatic wr(input logic [7:0] addr, input logic [7:0] data);
        u_sci_host_model.wr(addr, data);
    endtask
    task automatic pulse(input sci_events_t e);
        @(posedge clk_in);
        ev <= e;
        @(posedge clk_in);
        ev <= '0;
    endtask
    // lets the edge's own updates land before outputs are looked at
    task automatic wait_n(input int n);
        repeat (n) @(posedge clk_in);
        #1;
    endtask

    task automatic t_reset_values();
        logic [7:0] a [12] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h08, 8'h09, 8'h0a, 8'h0b, 8'h0e};
        logic [7:0] x [12] = '{CHIP_IDENTITY_VALUE[7:0], CHIP_IDENTITY_VALUE[15:8], VERSION_VALUE, RST_GEN_CTRL, RST_CLK_DIV,
                               8'h00, 8'h00, RST_IRQ_STA, RST_IRQ_EN, 8'h00, 8'h00, RST_PULSE};
        foreach (a[i]) rchk(a[i], x[i]);
        chk("clock stops", 16'h0006, {13'h0, pst, gst, sst});
    endtask
    task automatic t_control();
        wr(OFS_GEN_CTRL, 8'h18);
        rchk(OFS_GEN_CTRL, 8'h18);
        chk("sleep enable", 16'h0001, {15'h0, slp});
        wr(OFS_GEN_CTRL, 8'h00);
        wr(OFS_CLK_DIV, 8'hfb);
        rchk(OFS_CLK_DIV, 8'hfb);
        chk("clock stops", 16'h0003, {13'h0, pst, gst, sst});
        wr(OFS_CLK_DIV, 8'h45);
        rchk(OFS_CLK_DIV, 8'h45);
        chk("clock stops", 16'h0005, {13'h0, pst, gst, sst});
    endtask
    task automatic t_rates();
        int ne = 0;
        int ns = 0;
        int np = 0;
        wr(OFS_CLK_DIV, 8'h58);
        repeat (26000)
        begin
            @(posedge clk_in);
            ne += int'(eng === 1'b1);
            ns += int'(sen === 1'b1);
            np += int'(ptk === 1'b1);
        end
        chk("engine ticks", 16'h0208, 16'(ne));
        chk("sensor ticks in range", 16'h0001, {15'h0, ns >= 2 && ns <= 17});
        chk("pwm ticks in range", 16'h0001, {15'h0, np >= 32 && np <= 34});
    endtask
    task automatic t_slow_codes();
        int nz = 0;
        int nt = 0;
        wr(OFS_CLK_DIV, 8'h18);
        wait_n(1);
        repeat (4000) @(posedge clk_in) nz += int'(sen === 1'b1);
        wr(OFS_CLK_DIV, 8'hf8);
        wait_n(1);
        repeat (4000) @(posedge clk_in) nt += int'(sen === 1'b1);
        chk("reserved sensor code ticks", 16'h0000, 16'(nz));
        chk("slowest sensor code ticks", 16'h0000, 16'(nt));
    endtask
    task automatic t_level_irq();
        wr(OFS_IRQ_CTRL, 8'h05);
        wr(OFS_IRQ_EN, 8'h04);
        pulse('{touch: 1'b1, default: '0});
        wait_n(1);
        chk("irq level", 16'h0001, {15'h0, irq});
        wr(OFS_IRQ_STA, 8'hfb);
        rchk(OFS_IRQ_STA, 8'h04);
        chk("irq held", 16'h0001, {15'h0, irq});
        chk("key filter", 16'h0001, {15'h0, kfe});
        wr(OFS_IRQ_CTRL, 8'h01);
        wait_n(2);
        chk("irq active low", 16'h0000, {15'h0, irq});
        wr(OFS_IRQ_CTRL, 8'h00);
        wait_n(2);
        chk("irq disabled", 16'h0001, {15'h0, irq});
        wr(OFS_IRQ_STA, 8'h04);
        rchk(OFS_IRQ_STA, 8'h00);
    endtask
    task automatic t_edge_irq();
        wr(OFS_IRQ_CTRL, 8'h07);
        wr(OFS_IRQ_EN, 8'h02);
        pulse('{nearness: 1'b1, default: '0});
        wait_n(1);
        chk("edge pulse", 16'h0001, {15'h0, irq});
        wait_n(1);
        chk("edge pulse end", 16'h0000, {15'h0, irq});
        chk("key filter off", 16'h0000, {15'h0, kfe});
        rchk(OFS_IRQ_STA, 8'h02);
        wr(OFS_IRQ_STA, 8'h02);
    endtask
    task automatic t_sources();
        wr(OFS_IRQ_CTRL, 8'h05);
        wr(OFS_IRQ_EN, 8'hfe);
        for (int k = 0; k < 5; k++)
        begin
            pulse(sci_events_t'(29'h1 << k));
            wait_n(1);
            chk("irq per source", 16'h0001, {15'h0, irq});
            rchk(OFS_IRQ_STA, 8'h02 << k);
            wr(OFS_IRQ_STA, 8'h02 << k);
            wait_n(1);
            chk("irq cleared", 16'h0000, {15'h0, irq});
        end
    endtask
    task automatic t_sub_status();
        u_sci_host_model.gap = 3;
        wr(OFS_PIN_EN_MSB, 8'h02);
        wr(OFS_PULSE_EN, 8'h01);
        pulse('{pin_change: 16'h0200, pulse_done: 8'h81, default: '0});
        rchk(OFS_PIN_STA_MSB, 8'h02);
        rchk(OFS_PIN_STA_LSB, 8'h00);
        rchk(OFS_PULSE_STA, 8'h81);
        rchk(OFS_IRQ_STA, 8'hc0);
        wr(OFS_IRQ_STA, 8'hc0);
        rchk(OFS_IRQ_STA, 8'hc0);
        wr(OFS_PIN_STA_MSB, 8'h02);
        wr(OFS_PULSE_STA, 8'h81);
        wr(OFS_IRQ_STA, 8'hc0);
        rchk(OFS_IRQ_STA, 8'h00);
        u_sci_host_model.gap = 0;
    endtask
    task automatic t_hibernate();
        wr(OFS_GEN_CTRL, 8'h01);
        wait_n(1);
        chk("hibernate", 16'h0001, {15'h0, hib});
        rchk(OFS_GEN_CTRL, 8'h00);
        wait_n(1);
        chk("hibernate left", 16'h0000, {15'h0, hib});
        rchk(OFS_IRQ_STA, 8'h20);
        wr(OFS_IRQ_STA, 8'h20);
    endtask
    task automatic t_soft_reset();
        int n = 0;
        wr(OFS_GEN_CTRL, 8'h02);
        repeat (6)
        begin
            @(posedge clk_in);
            #1;
            n += int'(srst === 1'b1);
        end
        chk("soft reset pulses", 16'h0001, 16'(n));
        rchk(OFS_IRQ_EN, RST_IRQ_EN);
        rchk(OFS_CLK_DIV, RST_CLK_DIV);
    endtask

    initial forever #5 clk_in = ~clk_in;
    initial
    begin
        repeat (10) @(posedge clk_in);
        sys_rst_in <= 1'b0;
        t_reset_values();
        t_control();
        t_rates();
        t_slow_codes();
        t_level_irq();
        t_edge_irq();
        t_sources();
        t_sub_status();
        t_hibernate();
        t_soft_reset();
        conclude();
    end
    initial
    begin
        repeat (60000) @(posedge clk_in);
        errors++;
        conclude();
    end
endmodule
